// [core/dbw_ctrl.sv]
// Controller end: AXI4-Lite register file, strobe divider and burst sequencer.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dbw_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   dbw_if.ctrl link
);
   import dbw_pkg::*;

   typedef enum {ST_IDLE, ST_CMD, ST_WD0, ST_WD1, ST_RD0, ST_RD1} dbw_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // State.

   dbw_state_e state; // Sequencer state.
   logic [1:0] div; // Strobe divider.
   logic k_d; // Positive strobe, one cycle late.
   logic kn_d; // Negative strobe, one cycle late.
   logic pend_wr; // Write burst requested.
   logic pend_rd; // Read burst requested.
   logic single_reg; // Clock strap value.
   logic [ADDR_W-1:0] addr_reg; // Burst location.
   logic [31:0] wlo0; // Low bits of write word 0.
   logic [31:0] wlo1; // Low bits of write word 1.
   logic [31:0] wext; // High bits and selects of both words.
   logic [DATA_W-1:0] rd0; // Read word 0.
   logic [DATA_W-1:0] rd1; // Read word 1.
   logic aw_held; // Write address taken.
   logic w_held; // Write data taken.
   logic [7:0] aw_addr; // Held write address.
   logic [31:0] w_data; // Held write data.
   logic busy; // A burst is queued or running.
   logic do_write; // Register write happens this cycle.

   assign busy = (state != ST_IDLE) || pend_wr || pend_rd;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   ////////////////////////////////////////////////////////////////////////////
   // Strobe divider: one positive and one negative phase per burst clock.

   // [R22] Strobes run free outside reset and are held low during reset; no high parked level is driven.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div <= '0;
         link.k_rise <= 1'b0;
         link.kn_rise <= 1'b0;
         k_d <= 1'b0;
         kn_d <= 1'b0;
      end else begin
         div <= div + 2'h1;
         link.k_rise <= (div == K_LAST);
         link.kn_rise <= (div == KN_LAST);
         k_d <= link.k_rise;
         kn_d <= link.kn_rise;
      end
   end

   // Output strobes share the input phases; the strap goes out from its register.
   assign link.c_rise = link.k_rise;
   assign link.cn_rise = link.kn_rise;
   assign link.single_clock = single_reg;

   ////////////////////////////////////////////////////////////////////////////
   // AXI write channel: address and data taken in either order, then one response.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr > REG_REXT || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;

   // Register stores; writes while a burst runs leave the data registers alone.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         single_reg <= 1'b0;
         addr_reg <= '0;
         wlo0 <= '0;
         wlo1 <= '0;
         wext <= WEXT_RESET;
      end else if (do_write && !busy && s_axi_wstrb == 4'hF) begin
         case (aw_addr)
            REG_CTRL: single_reg <= w_data[CTRL_SINGLE];
            REG_ADDR: addr_reg <= w_data[ADDR_W-1:0];
            REG_WLO0: wlo0 <= w_data;
            REG_WLO1: wlo1 <= w_data;
            REG_WEXT: wext <= w_data;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI read channel: one-cycle answer.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: s_axi_rdata <= {29'h0, single_reg, 2'h0};
            REG_STATUS: s_axi_rdata <= {31'h0, busy};
            REG_ADDR: s_axi_rdata <= {29'h0, addr_reg};
            REG_WLO0: s_axi_rdata <= wlo0;
            REG_WLO1: s_axi_rdata <= wlo1;
            REG_WEXT: s_axi_rdata <= wext;
            REG_RLO0: s_axi_rdata <= rd0[31:0];
            REG_RLO1: s_axi_rdata <= rd1[31:0];
            REG_REXT: s_axi_rdata <= {24'h0, rd1[DATA_W-1:32], rd0[DATA_W-1:32]};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   ////////////////////////////////////////////////////////////////////////////
   // Burst sequencer.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         pend_wr <= 1'b0;
         pend_rd <= 1'b0;
         link.load_n <= 1'b1;
         link.read_write_n <= 1'b1;
         link.addr <= '0;
         link.wdata <= '0;
         link.byte_lane_write_select_n <= '1;
         link.half_byte_write_select_n <= '1;
         rd0 <= '0;
         rd1 <= '0;
      end else begin
         // Start requests are taken only while idle.
         if (do_write && !busy && aw_addr == REG_CTRL && s_axi_wstrb == 4'hF) begin
            pend_wr <= w_data[CTRL_WR];
            pend_rd <= w_data[CTRL_RD] && !w_data[CTRL_WR];
         end
         case (state)
            ST_IDLE: begin
               if (link.k_rise && (pend_wr || pend_rd)) begin
                  // [R23] Load low ahead of the start strobe.
                  link.load_n <= 1'b0;
                  link.read_write_n <= pend_rd;
                  link.addr <= addr_reg;
                  pend_wr <= 1'b0;
                  pend_rd <= 1'b0;
                  state <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (link.k_rise) begin
                  link.load_n <= 1'b1;
                  if (!link.read_write_n) begin
                     // [R1] [R24] Word 0 with its own selects.
                     link.wdata <= {wext[EXT_HI0 +: HI_W], wlo0};
                     link.byte_lane_write_select_n <= wext[EXT_SEL0 +: SEL_W];
                     link.half_byte_write_select_n <= wext[EXT_NIB0 +: NIB_W];
                     state <= ST_WD0;
                  end else begin
                     state <= ST_RD0;
                  end
               end
            end
            ST_WD0: begin
               if (link.k_rise) begin
                  // [R16] Word 1 may carry a different pattern.
                  link.wdata <= {wext[EXT_HI1 +: HI_W], wlo1};
                  link.byte_lane_write_select_n <= wext[EXT_SEL1 +: SEL_W];
                  link.half_byte_write_select_n <= wext[EXT_NIB1 +: NIB_W];
                  state <= ST_WD1;
               end
            end
            ST_WD1: begin
               if (link.kn_rise) begin
                  link.byte_lane_write_select_n <= '1;
                  link.half_byte_write_select_n <= '1;
                  state <= ST_IDLE;
               end
            end
            ST_RD0: begin
               if (kn_d && link.rdata_oe) begin
                  rd0 <= link.rdata;
                  state <= ST_RD1;
               end
            end
            ST_RD1: begin
               if (k_d) begin
                  rd1 <= link.rdata;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule : dbw_ctrl
`default_nettype wire

// [pkg/dbw_pkg.sv]
// Shared constants, types and lane decoding for the DDR burst SRAM write-mask link.
//
// Contract
// [R1] Each burst word is masked by its own selects.
// [R2] x8: both selects low store bits 7..0.
// [R3] x8: select 0 only stores bits 3..0.
// [R4] x8: select 1 only stores bits 7..4.
// [R5] x18: both selects low store bits 17..0.
// [R6] x18: select 0 only stores bits 8..0.
// [R7] x18: select 1 only stores bits 17..9.
// [R8] x8/x18: both selects high write nothing.
// [R9] x9: low select stores bits 8..0.
// [R10] x9 high or x36 all high: no write.
// [R11] x36: all selects low store 36 bits.
// [R12] x36: select 0 only stores bits 8..0.
// [R13] x36: select 1 only stores bits 17..9.
// [R14] x36: select 2 only stores bits 26..18.
// [R15] x36: select 3 only stores bits 35..27.
// [R16] Selects may change between the two words.
// [R17] Reset leaves device deselected, outputs released.
// [R18] Latch location; word 0 then word 1.
// [R19] Cycles t+1, t+2 follow start cycle t.
// [R20] Write data taken on both input strobes.
// [R21] Read data launched on output or input strobes.
// [R22] Controller parks clocks high when stopped; the strobes are held low in reset and never parked high.
// [R23] Write starts with load and write low.
// [R24] Each word paired with same-edge selects.
package dbw_pkg;

   // Data path and array geometry.
   localparam int DATA_W = 36;
   localparam int SEL_W = 4;
   localparam int NIB_W = 2;
   localparam int LANE_W = 9;
   localparam int NIB_BITS = 4;
   localparam int ADDR_W = 3;
   localparam int DEPTH = 2 ** (ADDR_W + 1);

   // Clock rates and the divider that makes the burst clock phases.
   localparam int CLK_PERIOD_NS = 10;
   localparam int K_PERIOD_NS = 40;
   localparam int K_DIV = K_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [1:0] K_LAST = 2'(K_DIV - 1);
   localparam logic [1:0] KN_LAST = 2'(K_DIV / 2 - 1);

   // Register byte offsets of the controller.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_WLO0 = 8'h0C;
   localparam logic [7:0] REG_WLO1 = 8'h10;
   localparam logic [7:0] REG_WEXT = 8'h14;
   localparam logic [7:0] REG_RLO0 = 8'h18;
   localparam logic [7:0] REG_RLO1 = 8'h1C;
   localparam logic [7:0] REG_REXT = 8'h20;

   // Field positions of the control and extension registers.
   localparam int CTRL_WR = 0;
   localparam int CTRL_RD = 1;
   localparam int CTRL_SINGLE = 2;
   localparam int EXT_HI0 = 0;
   localparam int EXT_HI1 = 4;
   localparam int EXT_SEL0 = 8;
   localparam int EXT_SEL1 = 12;
   localparam int EXT_NIB0 = 16;
   localparam int EXT_NIB1 = 18;
   localparam int HI_W = DATA_W - 32;

   // Reset value of the extension register: every select high, no lane written.
   localparam logic [31:0] WEXT_RESET = 32'h000FFF00;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Device organisations.
   typedef enum {ORG_X8, ORG_X9, ORG_X18, ORG_X36} dbw_org_e;

   // Turns the active-low selects of one word into a per-bit store enable.
   function automatic logic [DATA_W-1:0] lane_enable(
      input dbw_org_e org,
      input logic [SEL_W-1:0] bws_n,
      input logic [NIB_W-1:0] nws_n);
      logic [DATA_W-1:0] en;
      en = '0;
      case (org)
         // [R2] [R3] [R4] [R8] nibble lanes.
         ORG_X8: begin
            en[NIB_BITS-1:0] = {NIB_BITS{~nws_n[0]}};
            en[2*NIB_BITS-1:NIB_BITS] = {NIB_BITS{~nws_n[1]}};
         end
         // [R9] [R10] single lane.
         ORG_X9: begin
            en[LANE_W-1:0] = {LANE_W{~bws_n[0]}};
         end
         // [R5] [R6] [R7] [R8] [R11] [R12] [R13] [R14] [R15] byte lanes.
         default: begin
            for (int i = 0; i < SEL_W; i++) begin
               if (i < 2 || org == ORG_X36) begin
                  en[i*LANE_W +: LANE_W] = {LANE_W{~bws_n[i]}};
               end
            end
         end
      endcase
      return en;
   endfunction : lane_enable

endpackage : dbw_pkg

// [pkg/dbw_if.sv]
// Pin-level link between the burst SRAM and its controller.
`timescale 1ns/1ns
`default_nettype none
interface dbw_if;
   import dbw_pkg::*;

   logic k_rise; // Positive input clock rise, one-cycle strobe.
   logic kn_rise; // Negative input clock rise, one-cycle strobe.
   logic c_rise; // Positive output clock rise, one-cycle strobe.
   logic cn_rise; // Negative output clock rise, one-cycle strobe.
   logic single_clock; // Strap: high selects launch on the input strobes.
   logic load_n; // Low starts an operation at a positive strobe.
   logic read_write_n; // High read, low write.
   logic [ADDR_W-1:0] addr; // Location of the burst.
   logic [DATA_W-1:0] wdata; // Write data word.
   logic [SEL_W-1:0] byte_lane_write_select_n; // Byte lane selects, active low.
   logic [NIB_W-1:0] half_byte_write_select_n; // Nibble selects, active low.
   logic [DATA_W-1:0] rdata; // Read data word.
   logic rdata_oe; // High while the device drives read data.

   // Controller end.
   modport ctrl (
      output k_rise, kn_rise, c_rise, cn_rise, single_clock, load_n, read_write_n, addr,
      output wdata, byte_lane_write_select_n, half_byte_write_select_n,
      input rdata, rdata_oe
   );

   // Memory end.
   modport sram (
      input k_rise, kn_rise, c_rise, cn_rise, single_clock, load_n, read_write_n, addr,
      input wdata, byte_lane_write_select_n, half_byte_write_select_n,
      output rdata, rdata_oe
   );
endinterface : dbw_if
`default_nettype wire

// [core/dbw_sram.sv]
// Burst SRAM end: command latch, masked two-word writes and two-word reads.
`timescale 1ns/1ns
`default_nettype none
module dbw_sram #(
   parameter dbw_pkg::dbw_org_e ORG = dbw_pkg::ORG_X36
) (
   input wire logic aclk,
   input wire logic aresetn,
   dbw_if.sram link
);
   import dbw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Storage and state.

   logic [DATA_W-1:0] mem [DEPTH]; // Array, two words per location.
   logic wr_cmd; // A write was started at the last positive strobe.
   logic rd_cmd; // A read was started at the last positive strobe.
   logic [ADDR_W-1:0] cmd_addr; // Location latched with the command.
   logic wr_hi_pend; // Second write word is due at the negative strobe.
   logic [ADDR_W-1:0] wr_hi_addr; // Location of the pending second word.
   logic rd_arm; // First read word is due at the next negative output strobe.
   logic [ADDR_W-1:0] rd_arm_addr; // Location of the armed read.
   logic rd_hi; // Second read word is due at the next positive output strobe.
   logic [ADDR_W-1:0] rd_hi_addr; // Location of the second read word.
   logic strap_taken; // The clock strap has been caught.
   logic single_mode; // Read data follows the input strobes.
   logic out_pos; // Positive launch strobe.
   logic out_neg; // Negative launch strobe.
   logic [DATA_W-1:0] en_now; // Store enable of the word on the pins.

   ////////////////////////////////////////////////////////////////////////////
   // Clock strap, caught once at the first edge after reset release.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_taken <= 1'b0;
         single_mode <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         single_mode <= link.single_clock;
      end
   end

   // [R21] Launch strobe choice.
   assign out_pos = single_mode ? link.k_rise : link.c_rise;
   assign out_neg = single_mode ? link.kn_rise : link.cn_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Command latch at the positive input strobe (cycle t).

   // [R18] [R19] Latch the location.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_cmd <= 1'b0;
         rd_cmd <= 1'b0;
         cmd_addr <= '0;
      end else if (link.k_rise) begin
         wr_cmd <= !link.load_n && !link.read_write_n;
         rd_cmd <= !link.load_n && link.read_write_n;
         // The location is kept while no operation is issued.
         if (!link.load_n) begin
            cmd_addr <= link.addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write burst tracking: word 0 at t+1 positive, word 1 at the next negative.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_hi_pend <= 1'b0;
         wr_hi_addr <= '0;
      end else if (link.k_rise) begin
         // [R20] Second word follows the first.
         wr_hi_pend <= wr_cmd;
         wr_hi_addr <= cmd_addr;
      end else if (link.kn_rise) begin
         wr_hi_pend <= 1'b0;
      end
   end

   // [R24] Selects taken with the data word.
   assign en_now = lane_enable(ORG, link.byte_lane_write_select_n,
                               link.half_byte_write_select_n);

   // Array write; lanes without enable keep their contents.
   always_ff @(posedge aclk) begin
      // [R1] [R16] [R18] Word 0 at A plus 0.
      if (link.k_rise && wr_cmd) begin
         mem[{cmd_addr, 1'b0}] <= (mem[{cmd_addr, 1'b0}] & ~en_now) | (link.wdata & en_now);
      end
      // [R1] [R16] [R18] Word 1 at A plus 1.
      if (link.kn_rise && wr_hi_pend) begin
         mem[{wr_hi_addr, 1'b1}] <= (mem[{wr_hi_addr, 1'b1}] & ~en_now)
                                   | (link.wdata & en_now);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read arming: the command becomes due at t+1.

   // [R19] Arm at cycle t+1.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_arm <= 1'b0;
         rd_arm_addr <= '0;
      end else if (link.k_rise) begin
         rd_arm <= rd_cmd;
         rd_arm_addr <= cmd_addr;
      end else if (out_neg) begin
         // An armed read is used by one negative launch only.
         rd_arm <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data launch and output release.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // [R17] Deselected with outputs released.
         link.rdata <= '0;
         link.rdata_oe <= 1'b0;
         rd_hi <= 1'b0;
         rd_hi_addr <= '0;
      end else if (out_neg && rd_arm) begin
         // [R21] [R18] Word 0 at negative t+1.
         link.rdata <= mem[{rd_arm_addr, 1'b0}];
         link.rdata_oe <= 1'b1;
         rd_hi <= 1'b1;
         rd_hi_addr <= rd_arm_addr;
      end else if (out_pos) begin
         if (rd_hi) begin
            // [R21] [R18] Word 1 at positive t+2.
            link.rdata <= mem[{rd_hi_addr, 1'b1}];
            rd_hi <= 1'b0;
         end else begin
            // Release the bus one positive launch after the last word.
            link.rdata_oe <= 1'b0;
         end
      end
   end

endmodule : dbw_sram
`default_nettype wire

// [bench/dbw_link_checker.sv]
// Checker of the link between the burst SRAM and its controller.
`timescale 1ns/1ns
`default_nettype none
module dbw_link_checker
   import dbw_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic k_rise,
   input wire logic kn_rise,
   input wire logic c_rise,
   input wire logic cn_rise,
   input wire logic single_clock,
   input wire logic load_n,
   input wire logic read_write_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [SEL_W-1:0] byte_lane_write_select_n,
   input wire logic [NIB_W-1:0] half_byte_write_select_n,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic rdata_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////
   property p_kn_mid; k_rise |-> ##2 kn_rise; endproperty
   a_kn_mid: assert property (p_kn_mid) else $error("late negative strobe");
   property p_k_per; k_rise |=> !k_rise [*3] ##1 k_rise; endproperty
   a_k_per: assert property (p_k_per) else $error("bad strobe period");
   property p_oe_rise; $rose(rdata_oe) |-> $past(cn_rise); endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("output enable off strobe");
   property p_rst; !$past(aresetn) |-> !rdata_oe && load_n; endproperty
   a_rst: assert property (p_rst) else $error("not idle after reset");
   property p_wr; k_rise && !load_n && !read_write_n |-> ##4 k_rise && load_n; endproperty
   a_wr: assert property (p_wr) else $error("start held too long");
   property p_rd; k_rise && !load_n && read_write_n |-> ##7 rdata_oe [*6] ##1 !rdata_oe;
   endproperty
   a_rd: assert property (p_rd) else $error("read window wrong");
   property p_launch; !$past(c_rise) && !$past(cn_rise) |-> $stable(rdata); endproperty
   a_launch: assert property (p_launch) else $error("data off strobe");
   property p_sel; rdata_oe |-> &byte_lane_write_select_n && &half_byte_write_select_n;
   endproperty
   a_sel: assert property (p_sel) else $error("select low in read");
   cover property (k_rise && !load_n && !read_write_n);
   cover property (k_rise && !load_n && read_write_n);
   cover property (k_rise && !(&byte_lane_write_select_n) && (|byte_lane_write_select_n));
endmodule : dbw_link_checker
`default_nettype wire

// [bench/test_ddr_sram_byte_write_mask.sv]
// Testbench of the controller and burst SRAM joined over the link.
`timescale 1ns/1ns
`default_nettype none
module test_ddr_sram_byte_write_mask;
   import dbw_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, last_rd, seed;
   logic [1:0] bresp, rresp;
   logic [65:0] rq[$]; // Expected read: response, data, compare mask.
   logic [1:0] bq[$]; // Expected write responses.
   logic [35:0] mem[DEPTH]; // Reference copy of the array.
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   dbw_if link();
   dbw_ctrl i_dbw_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(link));
   dbw_sram #(.ORG(ORG_X36)) i_dbw_sram (.aclk(aclk), .aresetn(aresetn), .link(link));
   dbw_link_checker i_dbw_link_checker (.aclk(aclk), .aresetn(aresetn), .k_rise(link.k_rise),
      .kn_rise(link.kn_rise), .c_rise(link.c_rise), .cn_rise(link.cn_rise),
      .single_clock(link.single_clock), .load_n(link.load_n), .read_write_n(link.read_write_n),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rdata_oe(link.rdata_oe),
      .byte_lane_write_select_n(link.byte_lane_write_select_n),
      .half_byte_write_select_n(link.half_byte_write_select_n));
   ////////////////////////////////////////////////////////////
   // Free running clock and cycle limit against hangs.
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   // Addresses past the last register answer with an error.
   function automatic logic [1:0] resp_of(input logic [7:0] a);
      return (a > REG_REXT) ? RESP_SLVERR : RESP_OKAY;
   endfunction : resp_of
   task automatic chk(input logic [33:0] got, input logic [33:0] exp, input logic [33:0] m);
      cmp_count++;
      if ((got & m) !== (exp & m)) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Watches both answers and takes the oldest note for each.
   always @(posedge aclk) begin : mon
      logic [65:0] n;
      if (rvalid && rready && rq.size() > 0) begin
         n = rq.pop_front();
         chk({rresp, rdata}, n[65:32], {2'h3, n[31:0]});
      end
      if (bvalid && bready && bq.size() > 0) begin
         chk({32'h0, bresp}, {32'h0, bq.pop_front()}, '1);
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bq.push_back(resp_of(a));
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rq.push_back({resp_of(a), e, m});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      last_rd = rdata;
      rready <= 1'b0;
   endtask : rd
   // Waits until the sequencer reports idle.
   task automatic poll();
      do rd(REG_STATUS, 32'h0, 32'h0); while (last_rd[0] !== 1'b0);
   endtask : poll
   // One masked write burst, then a read back of both words.
   task automatic burst(input logic [2:0] a, input logic [3:0] s0, input logic [3:0] s1);
      logic [35:0] w0, w1;
      w0 = 36'({xs(), xs()});
      w1 = 36'({xs(), xs()});
      wr(REG_ADDR, {29'h0, a});
      wr(REG_WLO0, w0[31:0]);
      wr(REG_WLO1, w1[31:0]);
      wr(REG_WEXT, {12'h0, 4'hF, s1, s0, w1[35:32], w0[35:32]});
      wr(REG_CTRL, 32'h1);
      poll();
      for (int i = 0; i < SEL_W; i++) begin
         if (!s0[i]) mem[{a, 1'b0}][i*LANE_W +: LANE_W] = w0[i*LANE_W +: LANE_W];
         if (!s1[i]) mem[{a, 1'b1}][i*LANE_W +: LANE_W] = w1[i*LANE_W +: LANE_W];
      end
      wr(REG_CTRL, 32'h2);
      poll();
      rd(REG_RLO0, mem[{a, 1'b0}][31:0], '1);
      rd(REG_RLO1, mem[{a, 1'b1}][31:0], '1);
      rd(REG_REXT, {24'h0, mem[{a, 1'b1}][35:32], mem[{a, 1'b0}][35:32]}, 32'hFF);
   endtask : burst
   task automatic wrap_up();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////
   // Main sequence: reset, error paths, full fill, every mask pattern.
   initial begin
      seed = 32'h00009F47;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(REG_STATUS, 32'h0, 32'h1);
      rd(8'h24, 32'h0, '1);
      wr(8'h24, 32'h0);
      chk(34'(lane_enable(ORG_X8, 4'hF, 2'h2)), 34'h0000F, '1);
      chk(34'(lane_enable(ORG_X8, 4'hF, 2'h1)), 34'h000F0, '1);
      chk(34'(lane_enable(ORG_X8, 4'h0, 2'h3)), 34'h00000, '1);
      chk(34'(lane_enable(ORG_X18, 4'h2, 2'h0)), 34'h001FF, '1);
      chk(34'(lane_enable(ORG_X18, 4'h1, 2'h0)), 34'h3FE00, '1);
      chk(34'(lane_enable(ORG_X9, 4'hE, 2'h0)), 34'h001FF, '1);
      chk(34'(lane_enable(ORG_X9, 4'h1, 2'h0)), 34'h00000, '1);
      for (int a = 0; a < 8; a++) burst(3'(a), 4'h0, 4'h0);
      for (int i = 0; i < 16; i++) burst(3'(xs()), 4'(i), 4'(~i));
      wrap_up();
   end
endmodule : test_ddr_sram_byte_write_mask
`default_nettype wire
